/* hw/rst_ctl_pkg.sv */
// package: register map, reset values, timing and carrier types for the reset controller
package rst_ctl_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_GUARD_KEY = 8'h00;
    localparam logic [7:0] OFF_CAUSE_FLAGS = 8'h04;
    localparam logic [7:0] OFF_TIMEOUT_FLAGS = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h14;
    // guard key values
    localparam logic [7:0] GUARD_KEY_POR = 8'h55;
    localparam logic [7:0] GUARD_KEY_ALT = 8'hAA;
    // cause flag bit positions
    localparam int GUARD_FLAG_BIT = 3;
    localparam int WDCTL_FLAG_BIT = 0;
    localparam logic [7:0] CAUSE_FLAGS_MASK = 8'h09;
    // timeout/powerdown flag positions in the timeout flag register
    localparam int TIMEOUT_FLAG_BIT = 0;
    localparam int POWERDOWN_FLAG_BIT = 1;
    // interrupt status bits: one per reset source seen
    localparam int IRQ_PIN = 0;
    localparam int IRQ_GUARD = 1;
    localparam int IRQ_WD_RUN = 2;
    localparam int IRQ_WD_SLEEP = 3;
    localparam int IRQ_WDCTL = 4;
    localparam int IRQ_W = 5;
    // port reset value: all ones makes every pin an input
    localparam logic [7:0] PORT_RESET_VAL = 8'hFF;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int PIN_DELAY_US = 16;
    localparam int SW_DELAY_US = 16;
    localparam int POR_DELAY_US = 16;
    localparam int PIN_DELAY_CYC = PIN_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int SW_DELAY_CYC = SW_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int POR_DELAY_CYC = POR_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_PIN_HOLD = 3'b001,
        ST_DELAY = 3'b011,
        ST_RUN = 3'b010,
        ST_SW_WAIT = 3'b110
    } seq_state_t;

    typedef enum logic [1:0] {
        KIND_POR = 2'b00,
        KIND_WARM = 2'b01,
        KIND_SLEEP_WD = 2'b10
    } rst_kind_t;

    // reset requests toward the core
    typedef struct packed {
        logic core_rst;
        logic pc_sp_clear;
        logic regs_clear;
        logic ports_preset;
    } core_reset_t;

    typedef struct packed {
        seq_state_t state;
        rst_kind_t kind;
        logic [CNT_W-1:0] cnt;
        logic [7:0] guard_key;
        logic guard_flag;
        logic wdctl_flag;
        logic timeout_flag;
        logic powerdown_flag;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic sw_reset_req;
        core_reset_t out;
        logic pin_s1;
        logic pin_s2;
        logic wd_s1;
        logic wd_s2;
        logic aw_seen;
        logic [7:0] aw_addr;
        logic w_seen;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ctl_state_t;
endpackage

/* hw/reset_source_control.sv */
// reset source controller: merges power-on, pin, guard key and watchdog resets
`timescale 1ns/1ps
`default_nettype none
module reset_source_control (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic nrst,
    // external reset pin
    input wire logic ext_reset_pin_n,
    // watchdog side
    input wire logic wd_timeout,
    input wire logic wd_ctl_invalid,
    input wire logic low_power_mode,
    // core reset controls
    output rst_ctl_pkg::core_reset_t core_reset,
    output logic [7:0] port_preset_val,
    // interrupt
    output logic irq,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic rst_s1_ff;
    logic rst_s2_ff;
    rst_ctl_pkg::ctl_state_t st_ff;
    rst_ctl_pkg::ctl_state_t nxt_st;

    function automatic logic key_valid(input logic [7:0] k);
        key_valid = (k == rst_ctl_pkg::GUARD_KEY_POR) || (k == rst_ctl_pkg::GUARD_KEY_ALT);
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == rst_ctl_pkg::OFF_GUARD_KEY) || (a == rst_ctl_pkg::OFF_CAUSE_FLAGS)
            || (a == rst_ctl_pkg::OFF_TIMEOUT_FLAGS) || (a == rst_ctl_pkg::OFF_IRQ_STATUS)
            || (a == rst_ctl_pkg::OFF_IRQ_MASK) || (a == rst_ctl_pkg::OFF_CONTROL);
    endfunction

    // reset release through two flops so every register leaves reset together
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    logic aw_go;
    logic w_go;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;

    always_comb begin
        s_axi_awready = !st_ff.aw_seen && !st_ff.bvalid;
        s_axi_wready = !st_ff.w_seen && !st_ff.bvalid;
        s_axi_arready = !st_ff.rvalid;
        s_axi_bvalid = st_ff.bvalid;
        s_axi_bresp = st_ff.bresp;
        s_axi_rvalid = st_ff.rvalid;
        s_axi_rdata = st_ff.rdata;
        s_axi_rresp = st_ff.rresp;
        core_reset = st_ff.out;
        port_preset_val = rst_ctl_pkg::PORT_RESET_VAL;
        irq = |(st_ff.irq_status & st_ff.irq_mask);
        aw_go = s_axi_awvalid && s_axi_awready;
        w_go = s_axi_wvalid && s_axi_wready;
        wr_addr = st_ff.aw_seen ? st_ff.aw_addr : s_axi_awaddr;
        wr_data = st_ff.w_seen ? st_ff.w_data : s_axi_wdata;
        wr_fire = (st_ff.aw_seen || aw_go) && (st_ff.w_seen || w_go);
        rd_fire = s_axi_arvalid && s_axi_arready;
        rd_addr = s_axi_araddr;
        wr_byte = wr_data[7:0];
        wr_lane0 = st_ff.w_seen ? 1'b1 : s_axi_wstrb[0];
    end

    localparam int IRQ_EV_W = rst_ctl_pkg::IRQ_W;
    logic [IRQ_EV_W-1:0] ev;
    logic start_warm;
    logic start_sleep;

    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        start_warm = 1'b0;
        start_sleep = 1'b0;
        // pin and watchdog inputs come from outside this clock domain
        nxt_st.pin_s1 = ext_reset_pin_n;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.wd_s1 = wd_timeout;
        nxt_st.wd_s2 = st_ff.wd_s1;

        case (st_ff.state)
            rst_ctl_pkg::ST_POR: begin
                nxt_st.out.core_rst = 1'b1;
                nxt_st.out.pc_sp_clear = 1'b1;
                nxt_st.out.regs_clear = 1'b1;
                nxt_st.out.ports_preset = 1'b1;
                if (st_ff.pin_s2) begin
                    nxt_st.state = rst_ctl_pkg::ST_DELAY;
                    nxt_st.cnt = rst_ctl_pkg::CNT_W'(rst_ctl_pkg::POR_DELAY_CYC);
                end
            end
            rst_ctl_pkg::ST_PIN_HOLD: begin
                // core held while the pin stays low
                if (st_ff.pin_s2) begin
                    nxt_st.state = rst_ctl_pkg::ST_DELAY;
                    nxt_st.cnt = rst_ctl_pkg::CNT_W'(rst_ctl_pkg::PIN_DELAY_CYC);
                end
            end
            rst_ctl_pkg::ST_DELAY: begin
                if (!st_ff.pin_s2) begin
                    nxt_st.state = rst_ctl_pkg::ST_PIN_HOLD;
                end else if (st_ff.cnt <= rst_ctl_pkg::CNT_W'(1)) begin
                    nxt_st.state = rst_ctl_pkg::ST_RUN;
                    nxt_st.out = '0;
                    nxt_st.kind = rst_ctl_pkg::KIND_WARM;
                end else begin
                    nxt_st.cnt = st_ff.cnt - rst_ctl_pkg::CNT_W'(1);
                end
            end
            rst_ctl_pkg::ST_RUN: begin
                nxt_st.out.pc_sp_clear = 1'b0;
                nxt_st.out.core_rst = 1'b0;
                if (!st_ff.pin_s2) begin
                    start_warm = 1'b1;
                    ev[rst_ctl_pkg::IRQ_PIN] = 1'b1;
                end else if (st_ff.wd_s2 && !low_power_mode) begin
                    start_warm = 1'b1;
                    nxt_st.timeout_flag = 1'b1;
                    ev[rst_ctl_pkg::IRQ_WD_RUN] = 1'b1;
                end else if (st_ff.wd_s2 && low_power_mode) begin
                    start_sleep = 1'b1;
                    nxt_st.timeout_flag = 1'b1;
                    nxt_st.powerdown_flag = 1'b1;
                    ev[rst_ctl_pkg::IRQ_WD_SLEEP] = 1'b1;
                end else if (!key_valid(st_ff.guard_key) || wd_ctl_invalid
                    || st_ff.sw_reset_req) begin
                    nxt_st.state = rst_ctl_pkg::ST_SW_WAIT;
                    nxt_st.cnt = rst_ctl_pkg::CNT_W'(rst_ctl_pkg::SW_DELAY_CYC);
                    nxt_st.sw_reset_req = 1'b0;
                    if (!key_valid(st_ff.guard_key)) begin
                        nxt_st.guard_flag = 1'b1;
                        ev[rst_ctl_pkg::IRQ_GUARD] = 1'b1;
                    end
                    if (wd_ctl_invalid) begin
                        nxt_st.wdctl_flag = 1'b1;
                        ev[rst_ctl_pkg::IRQ_WDCTL] = 1'b1;
                    end
                end
            end
            rst_ctl_pkg::ST_SW_WAIT: begin
                if (st_ff.cnt <= rst_ctl_pkg::CNT_W'(1)) begin
                    start_warm = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt - rst_ctl_pkg::CNT_W'(1);
                end
            end
            default: begin
                nxt_st.state = rst_ctl_pkg::ST_POR;
            end
        endcase

        if (start_warm) begin
            // warm reset: ports and most registers reinitialised, some kept
            nxt_st.state = rst_ctl_pkg::ST_PIN_HOLD;
            nxt_st.kind = rst_ctl_pkg::KIND_WARM;
            nxt_st.out.core_rst = 1'b1;
            nxt_st.out.pc_sp_clear = 1'b1;
            nxt_st.out.regs_clear = 1'b1;
            nxt_st.out.ports_preset = 1'b1;
            nxt_st.guard_key = rst_ctl_pkg::GUARD_KEY_POR;
        end
        if (start_sleep) begin
            // only pc and sp; core is not held, guard key untouched
            nxt_st.kind = rst_ctl_pkg::KIND_SLEEP_WD;
            nxt_st.out.pc_sp_clear = 1'b1;
        end

        // software side of the register file
        if (aw_go) begin
            nxt_st.aw_seen = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (w_go) begin
            nxt_st.w_seen = 1'b1;
            nxt_st.w_data = s_axi_wdata;
        end
        if (wr_fire) begin
            nxt_st.aw_seen = 1'b0;
            nxt_st.w_seen = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = known_addr(wr_addr) ? rst_ctl_pkg::RESP_OKAY
                : rst_ctl_pkg::RESP_SLVERR;
            if (wr_lane0 && !start_warm) begin
                case (wr_addr)
                    rst_ctl_pkg::OFF_GUARD_KEY: begin
                        nxt_st.guard_key = wr_byte;
                    end
                    rst_ctl_pkg::OFF_CAUSE_FLAGS: begin
                        // a zero clears, a one keeps; a set this cycle still wins
                        if (!wr_byte[rst_ctl_pkg::GUARD_FLAG_BIT]
                            && !ev[rst_ctl_pkg::IRQ_GUARD]) begin
                            nxt_st.guard_flag = 1'b0;
                        end
                        if (!wr_byte[rst_ctl_pkg::WDCTL_FLAG_BIT]
                            && !ev[rst_ctl_pkg::IRQ_WDCTL]) begin
                            nxt_st.wdctl_flag = 1'b0;
                        end
                    end
                    rst_ctl_pkg::OFF_IRQ_STATUS: begin
                        nxt_st.irq_status = st_ff.irq_status & ~wr_byte[IRQ_EV_W-1:0];
                    end
                    rst_ctl_pkg::OFF_IRQ_MASK: begin
                        nxt_st.irq_mask = wr_byte[IRQ_EV_W-1:0];
                    end
                    rst_ctl_pkg::OFF_CONTROL: begin
                        // a low-power watchdog event in this cycle keeps its flags set
                        if (wr_byte[0] && !ev[rst_ctl_pkg::IRQ_WD_SLEEP]) begin
                            nxt_st.powerdown_flag = 1'b0;
                            nxt_st.timeout_flag = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        nxt_st.irq_status = nxt_st.irq_status | ev;
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        if (rd_fire) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = known_addr(rd_addr) ? rst_ctl_pkg::RESP_OKAY
                : rst_ctl_pkg::RESP_SLVERR;
            case (rd_addr)
                rst_ctl_pkg::OFF_GUARD_KEY: begin
                    nxt_st.rdata = {24'h000000, st_ff.guard_key};
                end
                rst_ctl_pkg::OFF_CAUSE_FLAGS: begin
                    // unimplemented bits tie to zero
                    nxt_st.rdata = '0;
                    nxt_st.rdata[rst_ctl_pkg::GUARD_FLAG_BIT] = st_ff.guard_flag;
                    nxt_st.rdata[rst_ctl_pkg::WDCTL_FLAG_BIT] = st_ff.wdctl_flag;
                end
                rst_ctl_pkg::OFF_TIMEOUT_FLAGS: begin
                    nxt_st.rdata = '0;
                    nxt_st.rdata[rst_ctl_pkg::TIMEOUT_FLAG_BIT] = st_ff.timeout_flag;
                    nxt_st.rdata[rst_ctl_pkg::POWERDOWN_FLAG_BIT] = st_ff.powerdown_flag;
                end
                rst_ctl_pkg::OFF_IRQ_STATUS: begin
                    nxt_st.rdata = {27'h0, st_ff.irq_status};
                end
                rst_ctl_pkg::OFF_IRQ_MASK: begin
                    nxt_st.rdata = {27'h0, st_ff.irq_mask};
                end
                rst_ctl_pkg::OFF_CONTROL: begin
                    nxt_st.rdata = {29'h0, st_ff.state};
                end
                default: nxt_st.rdata = '0;
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
    end

    // power-on values; of the resets only power-on clears the flags, software writes also clear them
    always_ff @(posedge core_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            st_ff <= '{
                state: rst_ctl_pkg::ST_POR,
                kind: rst_ctl_pkg::KIND_POR,
                cnt: '0,
                guard_key: rst_ctl_pkg::GUARD_KEY_POR,
                guard_flag: 1'b0,
                wdctl_flag: 1'b0,
                timeout_flag: 1'b0,
                powerdown_flag: 1'b0,
                irq_status: '0,
                irq_mask: '0,
                sw_reset_req: 1'b0,
                out: '{core_rst: 1'b1, pc_sp_clear: 1'b1, regs_clear: 1'b1,
                    ports_preset: 1'b1},
                pin_s1: 1'b0,
                pin_s2: 1'b0,
                wd_s1: 1'b0,
                wd_s2: 1'b0,
                aw_seen: 1'b0,
                aw_addr: '0,
                w_seen: 1'b0,
                w_data: '0,
                bvalid: 1'b0,
                bresp: '0,
                rvalid: 1'b0,
                rdata: '0,
                rresp: '0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

/* bench/rst_ctl_asserts.sv */
// checker: port timing relations of the reset controller
`timescale 1ns/1ps
`default_nettype none
module rst_ctl_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // reset sources
    input wire logic ext_reset_pin_n,
    input wire logic wd_timeout,
    input wire logic low_power_mode,
    // core side
    input wire rst_ctl_pkg::core_reset_t core_reset,
    input wire logic [7:0] port_preset_val,
    // bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // watchdog held three cycles while the core runs, outside and then inside low-power mode
    sequence wd_run_s;
        (wd_timeout && !low_power_mode && ext_reset_pin_n && !core_reset.core_rst) [*3];
    endsequence
    sequence wd_sleep_s;
        (wd_timeout && low_power_mode && ext_reset_pin_n && !core_reset.core_rst) [*3];
    endsequence
    release_hold_a: assert property ($rose(nrst) |-> core_reset.core_rst [*8])
        else $error("core left reset right after release");
    pin_hold_a: assert property ((!ext_reset_pin_n) [*5] |-> core_reset.core_rst && core_reset.regs_clear)
        else $error("core not held while pin low");
    pin_delay_a: assert property ($rose(ext_reset_pin_n) |-> core_reset.core_rst [*8])
        else $error("core released without delay");
    wd_run_a: assert property (wd_run_s |-> ##[0:4] core_reset.core_rst)
        else $error("running watchdog gave no warm reset");
    wd_sleep_a: assert property (wd_sleep_s |-> ##[0:4] core_reset.pc_sp_clear)
        else $error("sleep watchdog gave no pc clear");
    sleep_warm_a: assert property (wd_sleep_s |-> !core_reset.core_rst [*6])
        else $error("sleep watchdog reset the whole core");
    port_val_a: assert property (core_reset.ports_preset |-> port_preset_val == 8'hFF)
        else $error("port preset value not all ones");
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
`default_nettype wire

/* bench/pin_core_model.sv */
// model of the reset pin rc network and of the core program counter
`timescale 1ns/1ps
`default_nettype none
module pin_core_model #(parameter int RC_CYC = 6) (
    // clock and pin pull
    input wire logic core_clk,
    input wire logic pull_low,
    // core side
    input wire rst_ctl_pkg::core_reset_t core_reset,
    output logic ext_reset_pin_n,
    output logic [15:0] pc
);
    int rc_cnt = RC_CYC;
    // capacitor charges slowly, so the pin crosses its threshold late
    always @(posedge core_clk) begin
        if (pull_low) rc_cnt <= 0;
        else if (rc_cnt < RC_CYC) rc_cnt <= rc_cnt + 1;
    end
    assign ext_reset_pin_n = (rc_cnt >= RC_CYC);
    // core counts while free; either clear request zeroes it
    always @(posedge core_clk) begin
        if (core_reset.core_rst || core_reset.pc_sp_clear) pc <= 16'h0000;
        else pc <= pc + 16'h0001;
    end
endmodule
`default_nettype wire

/* bench/tb_reset_source_control.sv */
// testbench: register accesses and reset scenarios for the reset controller
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_control;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic pull_low = 1'b0;
    logic ext_reset_pin_n;
    logic wd_timeout = 1'b0;
    logic wd_ctl_invalid = 1'b0;
    logic low_power_mode = 1'b0;
    rst_ctl_pkg::core_reset_t core_reset;
    logic [7:0] port_preset_val;
    logic irq;
    logic [15:0] pc;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    always #12.5 core_clk = ~core_clk;
    reset_source_control i_dut (.core_clk(core_clk), .nrst(nrst),
        .ext_reset_pin_n(ext_reset_pin_n), .wd_timeout(wd_timeout),
        .wd_ctl_invalid(wd_ctl_invalid), .low_power_mode(low_power_mode),
        .core_reset(core_reset), .port_preset_val(port_preset_val), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    pin_core_model i_model (.core_clk(core_clk), .pull_low(pull_low), .core_reset(core_reset),
        .ext_reset_pin_n(ext_reset_pin_n), .pc(pc));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dat;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge core_clk);
        while (s_axi_arready !== 1'b1) @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        @(posedge core_clk);
        while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
        dat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dat;
        logic [1:0] resp;
        rd(a, dat, resp);
        chk(nm, dat, exp);
    endtask
    // counts cycles until core_rst reaches the given level, power-on or warm
    task automatic wait_rst(input logic lvl, output int cyc);
        cyc = 0;
        while (core_reset.core_rst !== lvl && cyc < 3000) begin
            @(posedge core_clk);
            cyc++;
        end
        if (cyc >= 3000) mismatches++;
    endtask
    task automatic pulse(input bit ctl);
        if (ctl) wd_ctl_invalid <= 1'b1;
        else wd_timeout <= 1'b1;
        repeat (3) @(posedge core_clk);
        wd_ctl_invalid <= 1'b0;
        wd_timeout <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        chk("por_outputs", 32'(core_reset), 32'h0000000F);
        chk("port_val", 32'(port_preset_val), 32'h000000FF);
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        wait_rst(1'b0, n);
        chk("por_delay", 32'(n >= 640 && n <= 660), 32'h1);
        chk("pc_start", 32'(pc < 16'h0004), 32'h1);
        rdc("guard_por", rst_ctl_pkg::OFF_GUARD_KEY, 32'h55);
        rdc("cause_por", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h00);
        rdc("tflags_por", rst_ctl_pkg::OFF_TIMEOUT_FLAGS, 32'h00);
        wr(rst_ctl_pkg::OFF_GUARD_KEY, 32'hAA);
        rdc("guard_alt", rst_ctl_pkg::OFF_GUARD_KEY, 32'hAA);
        repeat (700) @(posedge core_clk);
        chk("alt_no_reset", 32'(core_reset.core_rst), 32'h0);
        pulse(1'b0);
        wait_rst(1'b1, n);
        chk("wd_run_rst", 32'(n < 8), 32'h1);
        wait_rst(1'b0, n);
        rdc("tflags_wd", rst_ctl_pkg::OFF_TIMEOUT_FLAGS, 32'h01);
        rdc("guard_wd", rst_ctl_pkg::OFF_GUARD_KEY, 32'h55);
        wr(rst_ctl_pkg::OFF_GUARD_KEY, 32'hAA);
        pull_low <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk("pin_hold", 32'(core_reset), 32'h0000000F);
        pull_low <= 1'b0;
        wait_rst(1'b0, n);
        chk("pin_delay", 32'(n >= 640 && n <= 670), 32'h1);
        chk("pc_pin", 32'(pc < 16'h0004), 32'h1);
        rdc("tflags_pin", rst_ctl_pkg::OFF_TIMEOUT_FLAGS, 32'h01);
        rdc("guard_pin", rst_ctl_pkg::OFF_GUARD_KEY, 32'h55);
        wr(rst_ctl_pkg::OFF_CONTROL, 32'h01);
        wr(rst_ctl_pkg::OFF_GUARD_KEY, 32'hAA);
        low_power_mode <= 1'b1;
        pulse(1'b0);
        repeat (10) @(posedge core_clk);
        chk("sleep_no_rst", 32'(core_reset.core_rst), 32'h0);
        chk("pc_sleep", 32'(pc < 16'h000C), 32'h1);
        low_power_mode <= 1'b0;
        rdc("tflags_sleep", rst_ctl_pkg::OFF_TIMEOUT_FLAGS, 32'h03);
        rdc("guard_sleep", rst_ctl_pkg::OFF_GUARD_KEY, 32'hAA);
        wr(rst_ctl_pkg::OFF_GUARD_KEY, 32'h12);
        rdc("cause_guard", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h08);
        wait_rst(1'b1, n);
        chk("sw_delay", 32'(n >= 620 && n <= 660), 32'h1);
        wait_rst(1'b0, n);
        rdc("guard_sw", rst_ctl_pkg::OFF_GUARD_KEY, 32'h55);
        wr(rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'hFF);
        rdc("cause_keep", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h08);
        wr(rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h00);
        rdc("cause_clear", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h00);
        pulse(1'b1);
        wait_rst(1'b1, n);
        wait_rst(1'b0, n);
        rdc("cause_wdctl", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h01);
        wr(rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h00);
        rdc("wdctl_clear", rst_ctl_pkg::OFF_CAUSE_FLAGS, 32'h00);
        rdc("irq_all", rst_ctl_pkg::OFF_IRQ_STATUS, 32'h1F);
        wr(rst_ctl_pkg::OFF_IRQ_MASK, 32'h00);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(rst_ctl_pkg::OFF_IRQ_MASK, 32'h04);
        chk("irq_on", 32'(irq), 32'h1);
        wr(rst_ctl_pkg::OFF_IRQ_STATUS, 32'h04);
        chk("irq_off", 32'(irq), 32'h0);
        rdc("irq_left", rst_ctl_pkg::OFF_IRQ_STATUS, 32'h1B);
        rd(8'h40, d, r);
        chk("unmapped_resp", 32'(r), 32'(rst_ctl_pkg::RESP_SLVERR));
        chk("unmapped_data", d, 32'h0);
        wr(8'h40, 32'h0);
        chk("unmapped_wresp", 32'(r), 32'(rst_ctl_pkg::RESP_SLVERR));
        report_and_stop;
    end
endmodule
bind reset_source_control rst_ctl_asserts i_chk (.core_clk(core_clk), .nrst(nrst),
    .ext_reset_pin_n(ext_reset_pin_n), .wd_timeout(wd_timeout), .low_power_mode(low_power_mode),
    .core_reset(core_reset), .port_preset_val(port_preset_val), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
